// ==== pvp_frost.sv ====
`timescale 1ns/1ps
module pvp_frost
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // time base and settings
   input wire logic secTick,
   input wire logic enable,
   input wire logic signed [7:0] tempC,
   input wire logic signed [7:0] contThr,
   input wire logic signed [7:0] cycThr,
   // pump demand
   output logic run
);
   typedef struct packed {
      pvp_pkg::pvp_frost_t mode;
      logic phaseOn;
      logic [9:0] cnt;
   } pvp_fr_st_t;
   pvp_fr_st_t st_ff;
   pvp_fr_st_t nxt_st;

   ////////////////////////////////////////////////////////////////
   // band selection with hysteresis, then cycle timing
   always_comb
   begin
      nxt_st = st_ff;
      if (!enable)
      begin
         nxt_st.mode = pvp_pkg::PVP_FR_OFF;
      end
      else
      begin
         case (st_ff.mode)
            pvp_pkg::PVP_FR_OFF:
            begin
               if (tempC <= cycThr)
               begin
                  nxt_st.mode = pvp_pkg::PVP_FR_CYC;
                  nxt_st.phaseOn = 1'b1;
                  nxt_st.cnt = 10'h000;
               end
            end
            pvp_pkg::PVP_FR_CYC:
            begin
               if (tempC <= contThr)
               begin
                  nxt_st.mode = pvp_pkg::PVP_FR_CONT;
               end
               else if (tempC > cycThr + pvp_pkg::FROST_HYST)
               begin
                  nxt_st.mode = pvp_pkg::PVP_FR_OFF;
               end
            end
            pvp_pkg::PVP_FR_CONT:
            begin
               if (tempC > contThr + pvp_pkg::FROST_HYST)
               begin
                  nxt_st.mode = pvp_pkg::PVP_FR_CYC;
                  nxt_st.phaseOn = 1'b1;
                  nxt_st.cnt = 10'h000;
               end
            end
            default:
            begin
               nxt_st.mode = pvp_pkg::PVP_FR_OFF;
            end
         endcase
      end
      if (st_ff.mode == pvp_pkg::PVP_FR_CYC && nxt_st.mode == pvp_pkg::PVP_FR_CYC && secTick)
      begin
         if (st_ff.phaseOn && st_ff.cnt == 10'(pvp_pkg::FROST_ON_S - 1))
         begin
            nxt_st.phaseOn = 1'b0;
            nxt_st.cnt = 10'h000;
         end
         else if (!st_ff.phaseOn && st_ff.cnt == 10'(pvp_pkg::FROST_OFF_S - 1))
         begin
            nxt_st.phaseOn = 1'b1;
            nxt_st.cnt = 10'h000;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign run = (st_ff.mode == pvp_pkg::PVP_FR_CONT) || (st_ff.mode == pvp_pkg::PVP_FR_CYC && st_ff.phaseOn);
endmodule

// ==== pvp_overrun.sv ====
`timescale 1ns/1ps
module pvp_overrun
#(
   parameter bit CAN_OVERRUN = 1'b1
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // events and settings
   input wire logic secTick,
   input wire logic burnerOffEv,
   input wire logic req,
   input wire logic inhibit,
   input wire logic [pvp_pkg::RUN_W-1:0] loadSec,
   // overrun active
   output logic overrun
);
   typedef struct packed {
      logic [5:0] offCnt;
      logic [pvp_pkg::RUN_W-1:0] runCnt;
   } pvp_or_st_t;
   pvp_or_st_t st_ff;
   pvp_or_st_t nxt_st;

   ////////////////////////////////////////////////////////////////
   // age since switch-off and overrun countdown
   always_comb
   begin
      nxt_st = st_ff;
      // a consumer still demanding holds its switch-off age at zero, so the
      // age only starts counting once its demand drops
      if (req)
      begin
         nxt_st.offCnt = 6'h00;
      end
      else if (secTick && st_ff.offCnt < 6'(pvp_pkg::LAST_OFF_S))
      begin
         nxt_st.offCnt = st_ff.offCnt + 6'h01;
      end
      if (secTick && st_ff.runCnt != '0)
      begin
         nxt_st.runCnt = st_ff.runCnt - 1'b1;
      end
      if (CAN_OVERRUN && burnerOffEv && !req && st_ff.offCnt < 6'(pvp_pkg::LAST_OFF_S))
      begin
         nxt_st.runCnt = loadSec;
      end
      if (inhibit)
      begin
         nxt_st.runCnt = '0;
      end
   end

   // state register, switch-off age starts as long ago
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff.offCnt <= 6'(pvp_pkg::LAST_OFF_S);
         st_ff.runCnt <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign overrun = (st_ff.runCnt != '0);
endmodule

// ==== pvp_pkg.sv ====
package pvp_pkg;
   // time base
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_S = 1;
   localparam int MIN_S = 60;
   // protective timing, seconds
   localparam int KICK_S = 30;
   localparam int PAUSE_S = 30;
   localparam int VALVE_OPEN_S = 15;
   localparam int WEEK_S = 604800;
   localparam int MIN_OVERRUN_S = 60;
   localparam int LAST_OFF_S = 60;
   localparam int FROST_ON_S = 300;
   localparam int FROST_OFF_S = 900;
   // widths
   localparam int SEC_W = 20;
   localparam int RUN_W = 13;
   // temperatures, whole degrees, two's complement
   localparam logic signed [7:0] SUBST_TEMP = 8'sh00;
   localparam logic signed [7:0] FROST_HYST = 8'sh01;
   localparam logic signed [7:0] DEF_CYC_THR = 8'sh02;
   localparam logic signed [7:0] DEF_CONT_THR = 8'shFB;
   // factory settings for the driving side
   localparam logic [5:0] DEF_OVERRUN_MIN = 6'h06;
   localparam logic [5:0] DEF_SEC_OVERRUN_MIN = 6'h01;
   localparam logic [2:0] DEF_KICK_DAY = 3'h0;
   localparam logic [4:0] DEF_KICK_HOUR = 5'h0A;
   localparam logic [5:0] DEF_KICK_MIN = 6'h00;
   localparam logic DEF_FROST_EN = 1'b0;
   localparam logic [7:0] VALVE_FULL = 8'hFF;
   localparam logic [7:0] VALVE_SHUT = 8'h00;
   typedef enum logic [1:0] {
      PVP_SCOPE_OFF = 2'h0,
      PVP_SCOPE_PUMPS = 2'h1,
      PVP_SCOPE_VALVES = 2'h2,
      PVP_SCOPE_BOTH = 2'h3
   } pvp_scope_t;
   localparam pvp_scope_t DEF_SCOPE = PVP_SCOPE_BOTH;
   typedef enum logic [1:0] {
      PVP_FR_OFF = 2'h0,
      PVP_FR_CYC = 2'h1,
      PVP_FR_CONT = 2'h2
   } pvp_frost_t;
   typedef enum logic [1:0] {
      PVP_K_IDLE = 2'h0,
      PVP_K_SCAN = 2'h1,
      PVP_K_KICK = 2'h2,
      PVP_K_PAUSE = 2'h3
   } pvp_kick_t;
endpackage

// ==== pvp_sensor_model.sv ====
`timescale 1ns/1ps
module pvp_sensor_model
(
   // clock
   input wire logic ref_clk,
   // bench commands
   input wire logic signed [7:0] setTemp,
   input wire logic setFault,
   // sensor side
   output logic signed [7:0] outsideTemp = 8'sh0A,
   output logic sensorFault = 1'b0
);
   ////////////////////////////////////////
   // reading moves off the sampling edge; a broken sensor gives no usable
   // value, so it toggles every cycle, swinging through freezing readings
   // that a design trusting the pin would act on
   always @(negedge ref_clk)
   begin
      sensorFault <= setFault;
      if (setFault)
         outsideTemp <= ~outsideTemp;
      else
         outsideTemp <= setTemp;
   end
endmodule

// ==== pvp_sequencer.sv ====
`timescale 1ns/1ps
module pvp_sequencer
#(
   parameter int NP = 4,
   parameter int NV = 2,
   parameter int CYC_PER_SEC = pvp_pkg::CLK_HZ * pvp_pkg::TICK_S,
   parameter logic [NP-1:0] CIRC_MASK = 4'h4,
   parameter logic [NP-1:0] DHW_MASK = 4'h7,
   parameter int SEC_IDX = 1,
   parameter logic [NV-1:0] SHUTOFF_MASK = 2'h2
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // plant inputs
   input wire logic signed [7:0] outsideTemp,
   input wire logic sensorFault,
   input wire logic burnerOn,
   input wire logic dischargeProt,
   input wire logic hasBoiler,
   // normal control demands
   input wire logic [NP-1:0] pumpReq,
   input wire logic [NV-1:0] valveReq,
   input wire logic [NV-1:0][7:0] valveSet,
   // frost settings
   input wire logic signed [7:0] frost_continuous_threshold,
   input wire logic signed [7:0] frost_cycling_threshold,
   input wire logic [NP-1:0] frostEn,
   // overrun settings, minutes
   input wire logic [5:0] boilerOverrunMin,
   input wire logic [5:0] consumerOverrunMin,
   input wire logic [5:0] secOverrunMin,
   // calendar and kick settings
   input wire logic [2:0] dayOfWeek,
   input wire logic [4:0] hourOfDay,
   input wire logic [5:0] minuteOfHour,
   input wire logic [2:0] kickDay,
   input wire logic [4:0] kickHour,
   input wire logic [5:0] kickMinute,
   input wire pvp_pkg::pvp_scope_t kickScope,
   // drive outputs
   output logic [NP-1:0] pumpRun,
   output logic [NV-1:0][7:0] valvePos,
   // status
   output logic twinChangeover,
   output logic kickBusy,
   output logic [NP-1:0] frostRun,
   output logic [NP-1:0] overrunActive
);
   localparam int NT = NP + NV;
   localparam int DIV_W = $clog2(CYC_PER_SEC);
   localparam int IDX_W = $clog2(NT + 1);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic secTick;
      logic burnS1;
      logic burnS2;
      logic burnS3;
      logic faultS1;
      logic faultS2;
      logic matchQ;
      pvp_pkg::pvp_kick_t kst;
      logic [IDX_W-1:0] idx;
      logic [5:0] kcnt;
      logic [NT-1:0] due;
      logic [NT-1:0][pvp_pkg::SEC_W-1:0] idle;
      logic [NV-1:0][7:0] held;
      logic [NP-1:0] pumpRun;
      logic [NV-1:0][7:0] valvePos;
      logic twin;
   } pvp_st_t;

   pvp_st_t st_ff;
   pvp_st_t nxt_st;
   logic signed [7:0] tempEff;
   logic burnerOffEv;
   logic matchNow;
   logic [pvp_pkg::RUN_W-1:0] baseSec;
   logic [pvp_pkg::RUN_W-1:0] secLoad;
   logic [5:0] ovMin;

   ////////////////////////////////////////////////////////////////
   // minutes setting to seconds
   function automatic logic [pvp_pkg::RUN_W-1:0] minToSec(input logic [5:0] m);
      minToSec = pvp_pkg::RUN_W'(m) * pvp_pkg::RUN_W'(pvp_pkg::MIN_S);
   endfunction

   // scope allows this output kind
   function automatic logic scopeHas(input pvp_pkg::pvp_scope_t s, input logic isValve);
      scopeHas = isValve ? (s == pvp_pkg::PVP_SCOPE_VALVES || s == pvp_pkg::PVP_SCOPE_BOTH)
                         : (s == pvp_pkg::PVP_SCOPE_PUMPS || s == pvp_pkg::PVP_SCOPE_BOTH);
   endfunction

   ////////////////////////////////////////////////////////////////
   // derived settings and events
   // substitute temperature
   assign tempEff = st_ff.faultS2 ? pvp_pkg::SUBST_TEMP : outsideTemp;
   // edge seen only behind the second sync stage
   assign burnerOffEv = st_ff.burnS3 && !st_ff.burnS2;
   assign ovMin = hasBoiler ? boilerOverrunMin : consumerOverrunMin;
   assign baseSec = (minToSec(ovMin) < pvp_pkg::RUN_W'(pvp_pkg::MIN_OVERRUN_S))
                  ? pvp_pkg::RUN_W'(pvp_pkg::MIN_OVERRUN_S) : minToSec(ovMin);
   assign secLoad = baseSec + minToSec(secOverrunMin);
   assign matchNow = (dayOfWeek == kickDay) && (hourOfDay == kickHour) && (minuteOfHour == kickMinute);

   ////////////////////////////////////////////////////////////////
   // per pump frost and overrun units
   for (genvar i = 0; i < NP; i++)
   begin : g_pump
      pvp_frost u_frost
      (
         .ref_clk(ref_clk),
         .rst(rst),
         .secTick(st_ff.secTick),
         .enable(frostEn[i]),
         .tempC(tempEff),
         .contThr(frost_continuous_threshold),
         .cycThr(frost_cycling_threshold),
         .run(frostRun[i])
      );
      pvp_overrun
      #(
         .CAN_OVERRUN(!CIRC_MASK[i])
      )
      u_over
      (
         .ref_clk(ref_clk),
         .rst(rst),
         .secTick(st_ff.secTick),
         .burnerOffEv(burnerOffEv),
         .req(pumpReq[i] || (i < NV && valveReq[i < NV ? i : 0])),
         .inhibit(DHW_MASK[i] && dischargeProt),
         .loadSec((i == SEC_IDX) ? secLoad : baseSec),
         .overrun(overrunActive[i])
      );
   end

   ////////////////////////////////////////////////////////////////
   // time base, synchronisers, kick sequencer and output drive
   always_comb
   begin
      nxt_st = st_ff;
      // one second tick from the reference clock
      nxt_st.secTick = 1'b0;
      if (st_ff.div == DIV_W'(CYC_PER_SEC - 1))
      begin
         nxt_st.div = '0;
         nxt_st.secTick = 1'b1;
      end
      else
      begin
         nxt_st.div = st_ff.div + 1'b1;
      end
      // pin synchronisers
      nxt_st.burnS1 = burnerOn;
      nxt_st.burnS2 = st_ff.burnS1;
      nxt_st.burnS3 = st_ff.burnS2;
      nxt_st.faultS1 = sensorFault;
      nxt_st.faultS2 = st_ff.faultS1;
      nxt_st.matchQ = matchNow;
      // twin changeover at the kick moment
      nxt_st.twin = matchNow && !st_ff.matchQ;

      // kick state machine
      case (st_ff.kst)
         pvp_pkg::PVP_K_IDLE:
         begin
            if (matchNow && !st_ff.matchQ && kickScope != pvp_pkg::PVP_SCOPE_OFF)
            begin
               nxt_st.kst = pvp_pkg::PVP_K_SCAN;
               nxt_st.idx = '0;
               for (int t = 0; t < NT; t++)
               begin
                  // idle a week, in scope, not shutoff valve
                  nxt_st.due[t] = (st_ff.idle[t] >= pvp_pkg::SEC_W'(pvp_pkg::WEEK_S))
                               && scopeHas(kickScope, t >= NP)
                               && !(t >= NP && SHUTOFF_MASK[(t >= NP) ? t - NP : 0]);
               end
            end
         end
         pvp_pkg::PVP_K_SCAN:
         begin
            if (st_ff.idx == IDX_W'(NT))
            begin
               nxt_st.kst = pvp_pkg::PVP_K_IDLE;
            end
            else if (st_ff.due[st_ff.idx])
            begin
               nxt_st.kst = pvp_pkg::PVP_K_KICK;
               nxt_st.kcnt = '0;
            end
            else
            begin
               nxt_st.idx = st_ff.idx + 1'b1;
            end
         end
         pvp_pkg::PVP_K_KICK:
         begin
            if (st_ff.secTick)
            begin
               if (st_ff.kcnt == 6'(pvp_pkg::KICK_S - 1))
               begin
                  nxt_st.kst = pvp_pkg::PVP_K_PAUSE;
                  nxt_st.kcnt = '0;
               end
               else
               begin
                  nxt_st.kcnt = st_ff.kcnt + 6'h01;
               end
            end
         end
         pvp_pkg::PVP_K_PAUSE:
         begin
            if (st_ff.secTick)
            begin
               if (st_ff.kcnt == 6'(pvp_pkg::PAUSE_S - 1))
               begin
                  nxt_st.kst = pvp_pkg::PVP_K_SCAN;
                  nxt_st.idx = st_ff.idx + 1'b1;
                  nxt_st.kcnt = '0;
               end
               else
               begin
                  nxt_st.kcnt = st_ff.kcnt + 6'h01;
               end
            end
         end
         default:
         begin
            nxt_st.kst = pvp_pkg::PVP_K_IDLE;
         end
      endcase

      // pump drive: demand, frost, overrun or kick
      for (int p = 0; p < NP; p++)
      begin
         // one pump kicked at a time
         nxt_st.pumpRun[p] = pumpReq[p] || frostRun[p] || overrunActive[p]
                          || (st_ff.kst == pvp_pkg::PVP_K_KICK && st_ff.idx == IDX_W'(p));
      end

      // valve drive
      for (int v = 0; v < NV; v++)
      begin
         // remember the last setpoint while demanded
         if (valveReq[v])
         begin
            nxt_st.held[v] = valveSet[v];
         end
         if (st_ff.kst == pvp_pkg::PVP_K_KICK && st_ff.idx == IDX_W'(NP + v))
         begin
            nxt_st.valvePos[v] = (st_ff.kcnt < 6'(pvp_pkg::VALVE_OPEN_S)) ? pvp_pkg::VALVE_FULL
                                                                           : pvp_pkg::VALVE_SHUT;
         end
         else if (valveReq[v])
         begin
            nxt_st.valvePos[v] = valveSet[v];
         end
         else if (overrunActive[v])
         begin
            nxt_st.valvePos[v] = st_ff.held[v];
         end
         else
         begin
            nxt_st.valvePos[v] = pvp_pkg::VALVE_SHUT;
         end
      end

      // idle age, saturating at one week
      for (int t = 0; t < NT; t++)
      begin
         if ((t < NP) ? st_ff.pumpRun[(t < NP) ? t : 0] : (st_ff.valvePos[(t >= NP) ? t - NP : 0] != '0))
         begin
            nxt_st.idle[t] = '0;
         end
         else if (st_ff.secTick && st_ff.idle[t] < pvp_pkg::SEC_W'(pvp_pkg::WEEK_S))
         begin
            nxt_st.idle[t] = st_ff.idle[t] + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register; idle ages start at zero, so no kick right after power-up
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flip-flops, kickBusy decoded from the kick state
   assign pumpRun = st_ff.pumpRun;
   assign valvePos = st_ff.valvePos;
   assign twinChangeover = st_ff.twin;
   assign kickBusy = (st_ff.kst != pvp_pkg::PVP_K_IDLE);
endmodule

// ==== pvp_sequencer_props.sv ====
`timescale 1ns/1ps
module pvp_sequencer_props
#(
   parameter int NP = 4,
   parameter logic [NP-1:0] CIRC_MASK = 4'h4,
   parameter logic [NP-1:0] DHW_MASK = 4'h7
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // plant and settings
   input wire logic signed [7:0] outsideTemp,
   input wire logic sensorFault,
   input wire logic dischargeProt,
   input wire logic [NP-1:0] pumpReq,
   input wire logic signed [7:0] frost_continuous_threshold,
   input wire logic signed [7:0] frost_cycling_threshold,
   input wire logic [NP-1:0] frostEn,
   // calendar and kick
   input wire logic [2:0] dayOfWeek,
   input wire logic [4:0] hourOfDay,
   input wire logic [5:0] minuteOfHour,
   input wire logic [2:0] kickDay,
   input wire logic [4:0] kickHour,
   input wire logic [5:0] kickMinute,
   input wire pvp_pkg::pvp_scope_t kickScope,
   // drive and status
   input wire logic [NP-1:0] pumpRun,
   input wire logic twinChangeover,
   input wire logic kickBusy,
   input wire logic [NP-1:0] frostRun,
   input wire logic [NP-1:0] overrunActive
);
   ////////////////////////////////////////
   // kick moment and per pump run causes
   logic calMatch;
   logic [NP-1:0] cause;
   assign calMatch = dayOfWeek == kickDay && hourOfDay == kickHour && minuteOfHour == kickMinute;
   assign cause = pumpReq | frostRun | overrunActive;
   // one clock domain, so clock and reset are stated once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // pump follows cause
   a_pump_cause: assert property (1'b1 |=> (pumpRun & $past(cause)) == $past(cause))
      else $error("pump not running for its cause");
   a_pump_nocause: assert property (!kickBusy && !$past(kickBusy) |-> (pumpRun & ~$past(cause)) == '0)
      else $error("pump running without cause");
   a_frost_enable: assert property (1'b1 |=> (frostRun & ~$past(frostEn)) == '0)
      else $error("frost demand on disabled pump");
   // continuous when cold; four cycles cover the fault synchroniser
   a_frost_cont: assert property ((frostEn[0] && !sensorFault && outsideTemp <= frost_continuous_threshold)[*4]
      |=> frostRun[0])
      else $error("frost demand missing below continuous threshold");
   a_frost_warm: assert property ((frostEn[0] && !sensorFault
      && outsideTemp > frost_cycling_threshold + pvp_pkg::FROST_HYST)[*4] |=> !frostRun[0])
      else $error("frost demand above cycling threshold");
   a_circ_never: assert property ((overrunActive & CIRC_MASK) == '0)
      else $error("circulating pump in overrun");
   a_disch_clear: assert property (dischargeProt[*2] |-> (overrunActive & DHW_MASK) == '0)
      else $error("overrun kept during discharging protection");
   a_twin_match: assert property ($rose(calMatch) |=> twinChangeover)
      else $error("no changeover pulse at kick moment");
   a_twin_single: assert property (twinChangeover |-> $past(calMatch) ##1 !twinChangeover)
      else $error("changeover pulse malformed");
   a_kick_start: assert property ($rose(calMatch) && kickScope != pvp_pkg::PVP_SCOPE_OFF && !kickBusy
      |=> kickBusy)
      else $error("kick sequence not started");
   a_kick_off: assert property ($rose(calMatch) && kickScope == pvp_pkg::PVP_SCOPE_OFF && !kickBusy
      |=> !kickBusy)
      else $error("kick started while disabled");
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0, rst = 1'b1, burnerOn = 1'b1, dischargeProt = 1'b0, hasBoiler = 1'b1;
   logic [3:0] pumpReq = 4'h0, frostEn = 4'h0, pumpRun, frostRun, overrunActive;
   logic [1:0] valveReq = 2'h0;
   logic [1:0][7:0] valveSet = 16'h335A, valvePos;
   logic signed [7:0] frost_continuous_threshold = pvp_pkg::DEF_CONT_THR;
   logic signed [7:0] frost_cycling_threshold = pvp_pkg::DEF_CYC_THR;
   logic signed [7:0] setTemp = 8'sh0A, outsideTemp;
   logic [5:0] boilerOverrunMin = 6'h00, consumerOverrunMin = 6'h02;
   logic [5:0] secOverrunMin = pvp_pkg::DEF_SEC_OVERRUN_MIN, kickMinute = pvp_pkg::DEF_KICK_MIN;
   logic [5:0] minuteOfHour = 6'h00;
   logic [2:0] dayOfWeek = 3'h3, kickDay = pvp_pkg::DEF_KICK_DAY;
   logic [4:0] hourOfDay = 5'h0A, kickHour = pvp_pkg::DEF_KICK_HOUR;
   pvp_pkg::pvp_scope_t kickScope = pvp_pkg::DEF_SCOPE;
   logic setFault = 1'b0, sensorFault, twinChangeover, kickBusy;
   int nFail = 0, checkCount = 0, twinCnt = 0, kickCnt = 0;
   ////////////////////////////////////////
   // short second so frost and overrun spans fit the run
   pvp_sequencer #(.CYC_PER_SEC(4)) uut
   (
      .ref_clk, .rst, .outsideTemp, .sensorFault, .burnerOn, .dischargeProt, .hasBoiler,
      .pumpReq, .valveReq, .valveSet, .frost_continuous_threshold, .frost_cycling_threshold,
      .frostEn, .boilerOverrunMin, .consumerOverrunMin, .secOverrunMin, .dayOfWeek, .hourOfDay,
      .minuteOfHour, .kickDay, .kickHour, .kickMinute, .kickScope, .pumpRun, .valvePos,
      .twinChangeover, .kickBusy, .frostRun, .overrunActive
   );
   pvp_sensor_model plant (.ref_clk, .setTemp, .setFault, .outsideTemp, .sensorFault);
   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   // count one-cycle pulses, which a negedge sample could miss
   always @(posedge ref_clk)
   begin
      if (twinChangeover === 1'b1)
         twinCnt++;
      if ($rose(kickBusy))
         kickCnt++;
   end
   ////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp)
      begin
         nFail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   // main sequence
   initial
   begin
      step(12);
      chk("pumpRun", 8'h00, 8'(pumpRun));
      rst = 1'b0;
      setTemp = 8'shFA;
      step(20);
      chk("frostRun", 8'h00, 8'(frostRun));
      frostEn = 4'h5;
      step(400);
      chk("frostRun", 8'h05, 8'(frostRun));
      chk("pumpRun", 8'h05, 8'(pumpRun));
      setTemp = 8'sh0A;
      step(6);
      chk("frostRun", 8'h00, 8'(frostRun));
      // faulty sensor reads zero, cycling on then off
      setFault = 1'b1;
      step(8);
      chk("frostRun", 8'h05, 8'(frostRun));
      step(4 * pvp_pkg::FROST_ON_S + 20);
      chk("frostRun", 8'h00, 8'(frostRun));
      setFault = 1'b0;
      frostEn = 4'h0;
      // overrun after burner stop, both valves hold their setpoints
      pumpReq = 4'h7;
      valveReq = 2'h3;
      step(6);
      chk("valvePos0", 8'h5A, valvePos[0]);
      chk("valvePos1", 8'h33, valvePos[1]);
      pumpReq = 4'h0;
      valveReq = 2'h0;
      step(40);
      burnerOn = 1'b0;
      step(8);
      chk("overrunActive", 8'h03, 8'(overrunActive));
      chk("pumpRun", 8'h03, 8'(pumpRun));
      chk("valvePos0", 8'h5A, valvePos[0]);
      // sixty second floor, secondary pump extra minute
      step(4 * 50);
      chk("overrunActive", 8'h03, 8'(overrunActive));
      step(4 * 40);
      chk("overrunActive", 8'h02, 8'(overrunActive));
      chk("valvePos0", 8'h00, valvePos[0]);
      chk("valvePos1", 8'h33, valvePos[1]);
      dischargeProt = 1'b1;
      step(3);
      chk("overrunActive", 8'h00, 8'(overrunActive));
      chk("valvePos1", 8'h00, valvePos[1]);
      dischargeProt = 1'b0;
      burnerOn = 1'b1;
      // consumer setting of two minutes without boiler
      hasBoiler = 1'b0;
      pumpReq = 4'h1;
      step(8);
      pumpReq = 4'h0;
      step(8);
      burnerOn = 1'b0;
      step(4 * 100);
      chk("overrunActive", 8'h01, 8'(overrunActive));
      step(4 * 25);
      chk("overrunActive", 8'h00, 8'(overrunActive));
      burnerOn = 1'b1;
      // every scope at the default moment; nothing idle a week
      for (int s = 0; s < 4; s++)
      begin
         kickScope = pvp_pkg::pvp_scope_t'(s);
         dayOfWeek = 3'h0;
         step(20);
         chk("twinCnt", 8'(s + 1), 8'(twinCnt));
         chk("kickCnt", 8'(s), 8'(kickCnt));
         chk("kickBusy", 8'h00, {7'h00, kickBusy});
         chk("pumpRun", 8'h00, 8'(pumpRun));
         chk("valvePos0", 8'h00, valvePos[0]);
         dayOfWeek = 3'h3;
         step(4);
      end
      testDone;
   end
   // watchdog well above the roughly 2700 cycles the tests take
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      nFail++;
      testDone;
   end
endmodule

bind pvp_sequencer pvp_sequencer_props #(.NP(NP), .CIRC_MASK(CIRC_MASK), .DHW_MASK(DHW_MASK)) props
(
   .ref_clk, .rst, .outsideTemp, .sensorFault, .dischargeProt, .pumpReq, .frost_continuous_threshold,
   .frost_cycling_threshold, .frostEn, .dayOfWeek, .hourOfDay, .minuteOfHour, .kickDay, .kickHour,
   .kickMinute, .kickScope, .pumpRun, .twinChangeover, .kickBusy, .frostRun, .overrunActive
);
